// file: src/cpu_core_status_registers.sv
// module: core register set with flag and stack side effects
`timescale 1ns/1ps
module cpu_core_status_registers (
	// clock and reset
	input  wire logic                       clk_in,
	input  wire logic                       sys_rst_in,
	// special-function access
	input  wire core_regs_pkg::sfr_req_t    sfr_in,
	output logic [7:0]                      sfr_rdata_out,
	output logic                            sfr_hit_out,
	// operation request
	input  wire logic                       op_valid_in,
	input  wire core_regs_pkg::op_req_t     op_in,
	output logic                            op_ready_out,
	// stack memory
	output core_regs_pkg::stack_req_t       stack_out,
	input  wire logic [7:0]                 stack_rdata_in,
	// pointer and status
	output logic [15:0]                     data_pointer_out,
	output logic [7:0]                      bank_base_out,
	output logic [7:0]                      program_status_out,
	output logic [7:0]                      main_operand_out,
	output logic [15:0]                     pc_ret_out,
	output logic                            pc_ret_valid_out
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	core_regs_pkg::core_state_t s_r;
	core_regs_pkg::core_state_t s_nxt;

	logic [15:0] product;
	logic [7:0]  quotient;
	logic [7:0]  remainder;
	logic        div_zero;
	logic        parity_odd;
	logic        sel;
	logic [8:0]  sum9;
	logic [4:0]  sum5;
	logic [7:0]  acc_next;
	logic        cin;

	muldiv8 u_muldiv (
		.dividend_in  (s_r.main_operand),
		.divisor_in   (s_r.second_operand),
		.product_out  (product),
		.quotient_out (quotient),
		.remainder_out(remainder),
		.div_zero_out (div_zero)
	);

	parity8 u_parity (
		.data_in (s_nxt.main_operand),
		.odd_out (parity_odd)
	);

	assign sel = s_r.misc_control[core_regs_pkg::POINTER_SELECT_BIT];

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		s_nxt = s_r;
		s_nxt.stack.wr = 1'b0;
		s_nxt.stack.rd = 1'b0;
		s_nxt.pc_ret_valid = 1'b0;
		cin = s_r.program_status_word[core_regs_pkg::CARRY_FLAG_BIT];
		sum9 = 9'h000;
		sum5 = 5'h00;
		acc_next = s_r.main_operand;

		if (sfr_in.wr) begin
			case (sfr_in.addr)
				core_regs_pkg::ADDR_STACK_POINTER:     s_nxt.stack_pointer = sfr_in.wdata;
				core_regs_pkg::ADDR_DATA_POINTER_LOW: begin
					if (sel) s_nxt.data_pointer1[7:0] = sfr_in.wdata;
					else s_nxt.data_pointer0[7:0] = sfr_in.wdata;
				end
				core_regs_pkg::ADDR_DATA_POINTER_HIGH: begin
					if (sel) s_nxt.data_pointer1[15:8] = sfr_in.wdata;
					else s_nxt.data_pointer0[15:8] = sfr_in.wdata;
				end
				core_regs_pkg::ADDR_PROGRAM_STATUS:    s_nxt.program_status_word = sfr_in.wdata;
				core_regs_pkg::ADDR_MAIN_OPERAND:      s_nxt.main_operand = sfr_in.wdata;
				core_regs_pkg::ADDR_SECOND_OPERAND:    s_nxt.second_operand = sfr_in.wdata;
				core_regs_pkg::ADDR_MISC_CONTROL:      s_nxt.misc_control = sfr_in.wdata;
				default: ;
			endcase
		end

		// stack sequences: two bytes for pc, one for push/pop
		if (s_r.stack_phase != 2'd0) begin
			case (s_r.stack_phase)
				2'd1: begin
					s_nxt.stack_pointer = 8'(s_r.stack_pointer + 8'h01);
					s_nxt.stack.wr = 1'b1;
					s_nxt.stack.addr = 8'(s_r.stack_pointer + 8'h01);
					s_nxt.stack.wdata = s_r.pc_ret[15:8];
					s_nxt.stack_phase = 2'd0;
				end
				2'd2: begin
					s_nxt.pc_ret[15:8] = stack_rdata_in;
					s_nxt.stack.rd = 1'b1;
					s_nxt.stack.addr = s_r.stack_pointer;
					s_nxt.stack_pointer = 8'(s_r.stack_pointer - 8'h01);
					s_nxt.stack_phase = 2'd3;
				end
				2'd3: begin
					s_nxt.pc_ret[7:0] = stack_rdata_in;
					s_nxt.pc_ret_valid = 1'b1;
					s_nxt.stack_phase = 2'd0;
				end
				default: s_nxt.stack_phase = 2'd0;
			endcase
		end else if (op_valid_in) begin
			case (op_in.op)
				core_regs_pkg::OP_ADD, core_regs_pkg::OP_ADDC: begin
					if (op_in.op == core_regs_pkg::OP_ADD) cin = 1'b0;
					sum9 = 9'({1'b0, s_r.main_operand} + {1'b0, op_in.operand} + {8'h00, cin});
					sum5 = 5'({1'b0, s_r.main_operand[3:0]} + {1'b0, op_in.operand[3:0]} + {4'h0, cin});
					acc_next = sum9[7:0];
					s_nxt.program_status_word[core_regs_pkg::CARRY_FLAG_BIT] = sum9[8];
					s_nxt.program_status_word[core_regs_pkg::HALF_CARRY_FLAG_BIT] = sum5[4];
					s_nxt.program_status_word[core_regs_pkg::ARITH_RANGE_FLAG_BIT] =
						(s_r.main_operand[7] == op_in.operand[7]) && (acc_next[7] != s_r.main_operand[7]);
					s_nxt.main_operand = acc_next;
				end
				core_regs_pkg::OP_SUBB: begin
					sum9 = 9'({1'b0, s_r.main_operand} - {1'b0, op_in.operand} - {8'h00, cin});
					sum5 = 5'({1'b0, s_r.main_operand[3:0]} - {1'b0, op_in.operand[3:0]} - {4'h0, cin});
					acc_next = sum9[7:0];
					s_nxt.program_status_word[core_regs_pkg::CARRY_FLAG_BIT] = sum9[8];
					s_nxt.program_status_word[core_regs_pkg::HALF_CARRY_FLAG_BIT] = sum5[4];
					s_nxt.program_status_word[core_regs_pkg::ARITH_RANGE_FLAG_BIT] =
						(s_r.main_operand[7] != op_in.operand[7]) && (acc_next[7] != s_r.main_operand[7]);
					s_nxt.main_operand = acc_next;
				end
				core_regs_pkg::OP_MUL: begin
					s_nxt.main_operand = product[7:0];
					s_nxt.second_operand = product[15:8];
					s_nxt.program_status_word[core_regs_pkg::CARRY_FLAG_BIT] = 1'b0;
					s_nxt.program_status_word[core_regs_pkg::ARITH_RANGE_FLAG_BIT] = (product[15:8] != 8'h00);
				end
				core_regs_pkg::OP_DIV: begin
					s_nxt.main_operand = quotient;
					s_nxt.second_operand = remainder;
					s_nxt.program_status_word[core_regs_pkg::CARRY_FLAG_BIT] = 1'b0;
					s_nxt.program_status_word[core_regs_pkg::ARITH_RANGE_FLAG_BIT] = div_zero;
				end
				core_regs_pkg::OP_DECADJ: begin
					sum9 = {1'b0, s_r.main_operand};
					if ((sum9[3:0] > 4'h9) || s_r.program_status_word[core_regs_pkg::HALF_CARRY_FLAG_BIT])
						sum9 = 9'(sum9 + 9'h006);
					if ((sum9[7:4] > 4'h9) || sum9[8] || cin)
						sum9 = 9'(sum9 + 9'h060);
					s_nxt.main_operand = sum9[7:0];
					s_nxt.program_status_word[core_regs_pkg::CARRY_FLAG_BIT] = sum9[8] | cin;
				end
				core_regs_pkg::OP_ROT_R_C: begin
					s_nxt.main_operand = {cin, s_r.main_operand[7:1]};
					s_nxt.program_status_word[core_regs_pkg::CARRY_FLAG_BIT] = s_r.main_operand[0];
				end
				core_regs_pkg::OP_ROT_L_C: begin
					s_nxt.main_operand = {s_r.main_operand[6:0], cin};
					s_nxt.program_status_word[core_regs_pkg::CARRY_FLAG_BIT] = s_r.main_operand[7];
				end
				core_regs_pkg::OP_SET_C: s_nxt.program_status_word[core_regs_pkg::CARRY_FLAG_BIT] = 1'b1;
				core_regs_pkg::OP_CLR_C: s_nxt.program_status_word[core_regs_pkg::CARRY_FLAG_BIT] = 1'b0;
				core_regs_pkg::OP_CPL_C:  s_nxt.program_status_word[core_regs_pkg::CARRY_FLAG_BIT] = ~cin;
				core_regs_pkg::OP_AND_C:  s_nxt.program_status_word[core_regs_pkg::CARRY_FLAG_BIT] = cin & op_in.bit_in;
				core_regs_pkg::OP_AND_NC: s_nxt.program_status_word[core_regs_pkg::CARRY_FLAG_BIT] = cin & ~op_in.bit_in;
				core_regs_pkg::OP_OR_C:   s_nxt.program_status_word[core_regs_pkg::CARRY_FLAG_BIT] = cin | op_in.bit_in;
				core_regs_pkg::OP_OR_NC:  s_nxt.program_status_word[core_regs_pkg::CARRY_FLAG_BIT] = cin | ~op_in.bit_in;
				core_regs_pkg::OP_MOV_C:  s_nxt.program_status_word[core_regs_pkg::CARRY_FLAG_BIT] = op_in.bit_in;
				// compare sets carry when main operand is lower
				core_regs_pkg::OP_CMP_JMP:
					s_nxt.program_status_word[core_regs_pkg::CARRY_FLAG_BIT] = (s_r.main_operand < op_in.operand);
				// call: low byte first, high byte next cycle
				core_regs_pkg::OP_CALL: begin
					s_nxt.stack_pointer = 8'(s_r.stack_pointer + 8'h01);
					s_nxt.stack.wr = 1'b1;
					s_nxt.stack.addr = 8'(s_r.stack_pointer + 8'h01);
					s_nxt.stack.wdata = op_in.pc[7:0];
					s_nxt.pc_ret = op_in.pc;
					s_nxt.stack_phase = 2'd1;
				end
				// return: read high byte at top
				core_regs_pkg::OP_RETURN: begin
					s_nxt.stack.rd = 1'b1;
					s_nxt.stack.addr = s_r.stack_pointer;
					s_nxt.stack_pointer = 8'(s_r.stack_pointer - 8'h01);
					s_nxt.stack_phase = 2'd2;
				end
				core_regs_pkg::OP_PUSH: begin
					s_nxt.stack_pointer = 8'(s_r.stack_pointer + 8'h01);
					s_nxt.stack.wr = 1'b1;
					s_nxt.stack.addr = 8'(s_r.stack_pointer + 8'h01);
					s_nxt.stack.wdata = op_in.operand;
				end
				// pop reads then decrements; byte arrives next cycle on stack_rdata_in
				core_regs_pkg::OP_POP: begin
					s_nxt.stack.rd = 1'b1;
					s_nxt.stack.addr = s_r.stack_pointer;
					s_nxt.stack_pointer = 8'(s_r.stack_pointer - 8'h01);
				end
				default: ;
			endcase
		end

		// parity recomputed every cycle, overrides writes
		s_nxt.program_status_word[core_regs_pkg::PARITY_BIT] = parity_odd;

		// read data of the current address
		case (sfr_in.addr)
			core_regs_pkg::ADDR_STACK_POINTER:     s_nxt.sfr_rdata = s_r.stack_pointer;
			core_regs_pkg::ADDR_DATA_POINTER_LOW:  s_nxt.sfr_rdata = sel ? s_r.data_pointer1[7:0] : s_r.data_pointer0[7:0];
			core_regs_pkg::ADDR_DATA_POINTER_HIGH: s_nxt.sfr_rdata = sel ? s_r.data_pointer1[15:8] : s_r.data_pointer0[15:8];
			core_regs_pkg::ADDR_PROGRAM_STATUS:    s_nxt.sfr_rdata = s_r.program_status_word;
			core_regs_pkg::ADDR_MAIN_OPERAND:      s_nxt.sfr_rdata = s_r.main_operand;
			core_regs_pkg::ADDR_SECOND_OPERAND:    s_nxt.sfr_rdata = s_r.second_operand;
			core_regs_pkg::ADDR_MISC_CONTROL:      s_nxt.sfr_rdata = s_r.misc_control;
			default:                               s_nxt.sfr_rdata = core_regs_pkg::RST_ZERO;
		endcase
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			s_r <= '0;
			s_r.stack_pointer <= core_regs_pkg::RST_STACK_POINTER;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign sfr_rdata_out      = s_r.sfr_rdata;
	assign sfr_hit_out        = (sfr_in.addr == core_regs_pkg::ADDR_STACK_POINTER) ||
	                            (sfr_in.addr == core_regs_pkg::ADDR_DATA_POINTER_LOW) ||
	                            (sfr_in.addr == core_regs_pkg::ADDR_DATA_POINTER_HIGH) ||
	                            (sfr_in.addr == core_regs_pkg::ADDR_PROGRAM_STATUS) ||
	                            (sfr_in.addr == core_regs_pkg::ADDR_MAIN_OPERAND) ||
	                            (sfr_in.addr == core_regs_pkg::ADDR_SECOND_OPERAND) ||
	                            (sfr_in.addr == core_regs_pkg::ADDR_MISC_CONTROL);
	// sequences of two stack bytes stall new operations
	assign op_ready_out       = (s_r.stack_phase == 2'd0);
	assign stack_out          = s_r.stack;
	assign data_pointer_out   = sel ? s_r.data_pointer1 : s_r.data_pointer0;
	assign bank_base_out      = {3'b000, s_r.program_status_word[core_regs_pkg::BANK_SELECT_HIGH_BIT:
	                                     core_regs_pkg::BANK_SELECT_LOW_BIT], 3'b000};
	assign program_status_out = s_r.program_status_word;
	assign main_operand_out   = s_r.main_operand;
	assign pc_ret_out         = s_r.pc_ret;
	assign pc_ret_valid_out   = s_r.pc_ret_valid;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	property p_parity;
		@(posedge clk_in) disable iff (sys_rst_in)
		program_status_out[0] == ^main_operand_out;
	endproperty
	a_parity: assert property (p_parity) else $error("parity bit wrong");

	property p_set_carry;
		@(posedge clk_in) disable iff (sys_rst_in)
		(op_valid_in && op_ready_out && op_in.op == core_regs_pkg::OP_SET_C) |=> program_status_out[7];
	endproperty
	a_set_carry: assert property (p_set_carry) else $error("carry not set");

	property p_clr_carry;
		@(posedge clk_in) disable iff (sys_rst_in)
		(op_valid_in && op_ready_out && !sfr_in.wr && (op_in.op == core_regs_pkg::OP_CLR_C ||
		 op_in.op == core_regs_pkg::OP_MUL || op_in.op == core_regs_pkg::OP_DIV)) |=> !program_status_out[7];
	endproperty
	a_clr_carry: assert property (p_clr_carry) else $error("carry not cleared");

	property p_div;
		@(posedge clk_in) disable iff (sys_rst_in)
		(op_valid_in && op_ready_out && !sfr_in.wr && op_in.op == core_regs_pkg::OP_DIV &&
		 s_r.second_operand != 8'h00) |=> main_operand_out == 8'($past(s_r.main_operand) / $past(s_r.second_operand));
	endproperty
	a_div: assert property (p_div) else $error("quotient wrong");

	property p_mul_high;
		@(posedge clk_in) disable iff (sys_rst_in)
		(op_valid_in && op_ready_out && !sfr_in.wr && op_in.op == core_regs_pkg::OP_MUL) |=>
		({s_r.second_operand, main_operand_out} == 16'($past(s_r.main_operand) * $past(s_r.second_operand)));
	endproperty
	a_mul_high: assert property (p_mul_high) else $error("product wrong");

	property p_push;
		@(posedge clk_in) disable iff (sys_rst_in)
		(op_valid_in && op_ready_out && !sfr_in.wr && op_in.op == core_regs_pkg::OP_PUSH) |=>
		(stack_out.wr && stack_out.addr == s_r.stack_pointer && s_r.stack_pointer == 8'($past(s_r.stack_pointer) + 8'h01));
	endproperty
	a_push: assert property (p_push) else $error("push wrong");

	property p_call;
		@(posedge clk_in) disable iff (sys_rst_in)
		(op_valid_in && op_ready_out && !sfr_in.wr && op_in.op == core_regs_pkg::OP_CALL) |=>
		stack_out.wr ##1 (stack_out.wr && stack_out.wdata == $past(op_in.pc[15:8], 2) && op_ready_out);
	endproperty
	a_call: assert property (p_call) else $error("call sequence wrong");

	property p_ret;
		@(posedge clk_in) disable iff (sys_rst_in)
		(op_valid_in && op_ready_out && op_in.op == core_regs_pkg::OP_RETURN) |=> ##2 pc_ret_valid_out;
	endproperty
	a_ret: assert property (p_ret) else $error("return not finished");

	property p_pointer_sel;
		@(posedge clk_in) disable iff (sys_rst_in)
		data_pointer_out == (s_r.misc_control[0] ? s_r.data_pointer1 : s_r.data_pointer0);
	endproperty
	a_pointer_sel: assert property (p_pointer_sel) else $error("pointer select wrong");

	property p_bank;
		@(posedge clk_in) disable iff (sys_rst_in)
		bank_base_out == 8'(program_status_out[4:3] * 8);
	endproperty
	a_bank: assert property (p_bank) else $error("bank base wrong");

endmodule : cpu_core_status_registers

// file: src/core_regs_pkg.sv
// package: core register addresses, field positions, reset values and carriers
package core_regs_pkg;

	// ------------------------------------------------------------
	// special-function addresses
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_STACK_POINTER      = 8'h81;
	localparam logic [7:0] ADDR_DATA_POINTER_LOW   = 8'h82;
	localparam logic [7:0] ADDR_DATA_POINTER_HIGH  = 8'h83;
	localparam logic [7:0] ADDR_PROGRAM_STATUS     = 8'hD0;
	localparam logic [7:0] ADDR_MAIN_OPERAND       = 8'hE0;
	localparam logic [7:0] ADDR_SECOND_OPERAND     = 8'hF0;
	localparam logic [7:0] ADDR_MISC_CONTROL       = 8'hF8;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [7:0] RST_STACK_POINTER       = 8'h07;
	localparam logic [7:0] RST_ZERO                = 8'h00;

	// ------------------------------------------------------------
	// status word and control fields
	// ------------------------------------------------------------
	localparam int CARRY_FLAG_BIT      = 7;
	localparam int HALF_CARRY_FLAG_BIT = 6;
	localparam int USER_FLAG_ZERO_BIT  = 5;
	localparam int BANK_SELECT_HIGH_BIT = 4;
	localparam int BANK_SELECT_LOW_BIT = 3;
	localparam int ARITH_RANGE_FLAG_BIT = 2;
	localparam int USER_FLAG_ONE_BIT   = 1;
	localparam int PARITY_BIT          = 0;
	localparam int POINTER_SELECT_BIT  = 0;

	// ------------------------------------------------------------
	// operations presented by the sequencer
	// ------------------------------------------------------------
	typedef enum logic [4:0] {
		OP_NONE     = 5'h00,
		OP_ADD      = 5'h01,
		OP_ADDC     = 5'h02,
		OP_SUBB     = 5'h03,
		OP_MUL      = 5'h04,
		OP_DIV      = 5'h05,
		OP_DECADJ   = 5'h06,
		OP_ROT_R_C  = 5'h07,
		OP_ROT_L_C  = 5'h08,
		OP_SET_C    = 5'h09,
		OP_CLR_C    = 5'h0A,
		OP_CPL_C    = 5'h0B,
		OP_AND_C    = 5'h0C,
		OP_AND_NC   = 5'h0D,
		OP_OR_C     = 5'h0E,
		OP_OR_NC    = 5'h0F,
		OP_MOV_C    = 5'h10,
		OP_CMP_JMP  = 5'h11,
		OP_CALL     = 5'h12,
		OP_RETURN   = 5'h13,
		OP_PUSH     = 5'h14,
		OP_POP      = 5'h15
	} alu_op_t;

	// one operation request
	typedef struct packed {
		alu_op_t    op;
		logic [7:0] operand;
		logic       bit_in;
		logic [15:0] pc;
	} op_req_t;

	// special-function access
	typedef struct packed {
		logic       wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} sfr_req_t;

	// stack memory request
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} stack_req_t;

	// all architectural state
	typedef struct packed {
		logic [7:0]  main_operand;
		logic [7:0]  second_operand;
		logic [7:0]  stack_pointer;
		logic [15:0] data_pointer0;
		logic [15:0] data_pointer1;
		logic [7:0]  program_status_word;
		logic [7:0]  misc_control;
		logic [7:0]  sfr_rdata;
		logic [15:0] pc_ret;
		logic        pc_ret_valid;
		logic [1:0]  stack_phase;
		stack_req_t  stack;
	} core_state_t;

endpackage : core_regs_pkg

// file: src/parity8.sv
// module: parity of one byte, odd count gives one
`timescale 1ns/1ps
module parity8 (
	// data
	input  wire logic [7:0] data_in,
	// result
	output logic            odd_out
);
	assign odd_out = ^data_in;
endmodule : parity8

// file: src/muldiv8.sv
// module: eight-bit multiply and divide, combinational
`timescale 1ns/1ps
module muldiv8 (
	// operands
	input  wire logic [7:0] dividend_in,
	input  wire logic [7:0] divisor_in,
	// results
	output logic [15:0]     product_out,
	output logic [7:0]      quotient_out,
	output logic [7:0]      remainder_out,
	output logic            div_zero_out
);
	// divide by zero leaves operands unchanged, as on the classic core
	assign div_zero_out  = (divisor_in == 8'h00);
	assign product_out   = 16'(dividend_in * divisor_in);
	assign quotient_out  = div_zero_out ? dividend_in : 8'(dividend_in / divisor_in);
	assign remainder_out = div_zero_out ? divisor_in : 8'(dividend_in % divisor_in);
endmodule : muldiv8

// file: verif/cpu_core_status_registers_tb.sv
// testbench: core register set, flags, stack and pointers
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin n_compared++; if ((gt) !== (ex)) begin failures++; $display("[ERR] %s exp %h got %h", nm, ex, gt); end end
module cpu_core_status_registers_tb;
	logic                      clk_in;
	logic                      sys_rst_in;
	core_regs_pkg::sfr_req_t   sfr_in;
	logic [7:0]                sfr_rdata_out;
	logic                      sfr_hit_out;
	logic                      op_valid_in;
	core_regs_pkg::op_req_t    op_in;
	logic                      op_ready_out;
	core_regs_pkg::stack_req_t stack_out;
	logic [7:0]                stack_rdata_in;
	logic [15:0]               data_pointer_out;
	logic [7:0]                bank_base_out;
	logic [7:0]                program_status_out;
	logic [7:0]                main_operand_out;
	logic [15:0]               pc_ret_out;
	logic                      pc_ret_valid_out;
	logic [7:0]                mem [256];
	int                        failures;
	int                        n_compared;

	cpu_core_status_registers i_cpu_core_status_registers (.clk_in, .sys_rst_in, .sfr_in, .sfr_rdata_out,
		.sfr_hit_out, .op_valid_in, .op_in, .op_ready_out, .stack_out, .stack_rdata_in, .data_pointer_out,
		.bank_base_out, .program_status_out, .main_operand_out, .pc_ret_out, .pc_ret_valid_out);

	initial begin
		clk_in = 1'h0;
		forever #25 clk_in = ~clk_in;
	end

	// stack memory stand-in; read data stands while rd pulses, idle shows the inverse
	always @(posedge clk_in) begin
		if (stack_out.wr)
			mem[stack_out.addr] <= stack_out.wdata;
	end
	assign stack_rdata_in = stack_out.rd ? mem[stack_out.addr] : ~mem[stack_out.addr];

	// ------------------------------------------------------------
	// bus tasks
	// ------------------------------------------------------------
	task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in) sfr_in <= {1'h1, a, d};
		@(posedge clk_in) sfr_in.wr <= 1'h0;
		#1;
	endtask : sfr_wr

	task automatic sfr_chk(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk_in) sfr_in <= {1'h0, a, 8'h00};
		@(posedge clk_in) #1;
		`CHK("sfr read", e, sfr_rdata_out)
	endtask : sfr_chk

	task automatic do_op(input core_regs_pkg::alu_op_t o, input logic [7:0] v, input logic [15:0] pc);
		@(posedge clk_in) begin
			op_valid_in <= 1'h1;
			op_in       <= {o, v, 1'h0, pc};
		end
		@(posedge clk_in) op_valid_in <= 1'h0;
		#1;
	endtask : do_op

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		logic [7:0] a [8] = '{8'h81, 8'h82, 8'h83, 8'hD0, 8'hE0, 8'hF0, 8'hF8, 8'h90};
		for (int i = 0; i < 8; i++) begin
			sfr_chk(a[i], (i == 0) ? 8'h07 : 8'h00);
		end
		`CHK("unmapped hit", 1'h0, sfr_hit_out)
	endtask : t_reset

	task automatic t_status();
		sfr_wr(8'hE0, 8'h5A);
		`CHK("mapped hit", 1'h1, sfr_hit_out)
		`CHK("parity even", 2'h0, {main_operand_out[0], program_status_out[0]})
		sfr_wr(8'hE0, 8'h01);
		`CHK("parity odd", 1'h1, program_status_out[0])
		for (int b = 0; b < 4; b++) begin
			sfr_wr(8'hD0, 8'(b * 8) | 8'h22);
			`CHK("bank base", 8'(b * 8), bank_base_out)
			`CHK("user flags", 8'(b * 8) | 8'h23, program_status_out)
		end
		sfr_wr(8'hD0, 8'h00);
	endtask : t_status

	task automatic t_arith();
		sfr_wr(8'hE0, 8'h7F);
		do_op(core_regs_pkg::OP_ADD, 8'h01, 16'h0000);
		`CHK("add half", 12'h80_7, {main_operand_out, program_status_out[7:6], program_status_out[2], 1'h1})
		do_op(core_regs_pkg::OP_ADD, 8'h80, 16'h0000);
		`CHK("add carry", 3'h5, {program_status_out[7:6], program_status_out[2]})
		do_op(core_regs_pkg::OP_CLR_C, 8'h00, 16'h0000);
		`CHK("clear carry", 1'h0, program_status_out[7])
		do_op(core_regs_pkg::OP_SET_C, 8'h00, 16'h0000);
		`CHK("set carry", 1'h1, program_status_out[7])
		sfr_wr(8'hE0, 8'h17);
		sfr_wr(8'hF0, 8'h05);
		do_op(core_regs_pkg::OP_DIV, 8'h00, 16'h0000);
		`CHK("quotient", 10'h010, {main_operand_out, program_status_out[7], program_status_out[2]})
		sfr_chk(8'hF0, 8'h03);
		sfr_wr(8'hE0, 8'h20);
		sfr_wr(8'hF0, 8'h10);
		do_op(core_regs_pkg::OP_MUL, 8'h00, 16'h0000);
		`CHK("product low", 10'h001, {main_operand_out, program_status_out[7], program_status_out[2]})
		sfr_chk(8'hF0, 8'h02);
	endtask : t_arith

	task automatic t_stack();
		do_op(core_regs_pkg::OP_PUSH, 8'hA5, 16'h0000);
		`CHK("push", 17'h1_08A5, {stack_out.wr, stack_out.addr, stack_out.wdata})
		do_op(core_regs_pkg::OP_CALL, 8'h00, 16'h1234);
		`CHK("call low", 18'h2_0934, {stack_out.wr, op_ready_out, stack_out.addr, stack_out.wdata})
		@(posedge clk_in) #1;
		`CHK("call high", 18'h3_0A12, {stack_out.wr, op_ready_out, stack_out.addr, stack_out.wdata})
		do_op(core_regs_pkg::OP_RETURN, 8'h00, 16'h0000);
		`CHK("ret read", 10'h20A, {stack_out.rd, op_ready_out, stack_out.addr})
		for (int i = 0; i < 4 && pc_ret_valid_out !== 1'h1; i++) @(posedge clk_in) #1;
		`CHK("ret pc", 17'h1_1234, {pc_ret_valid_out, pc_ret_out})
		do_op(core_regs_pkg::OP_POP, 8'h00, 16'h0000);
		`CHK("pop", 9'h108, {stack_out.rd, stack_out.addr})
		sfr_chk(8'h81, 8'h07);
	endtask : t_stack

	task automatic t_pointer();
		sfr_wr(8'h82, 8'h34);
		sfr_wr(8'h83, 8'h12);
		`CHK("pointer 0", 16'h1234, data_pointer_out)
		sfr_wr(8'hF8, 8'h01);
		`CHK("pointer 1", 16'h0000, data_pointer_out)
		sfr_wr(8'h82, 8'hCD);
		sfr_wr(8'h83, 8'hAB);
		sfr_chk(8'h82, 8'hCD);
		sfr_wr(8'hF8, 8'h00);
		`CHK("pointer back", 16'h1234, data_pointer_out)
		sfr_chk(8'h83, 8'h12);
	endtask : t_pointer

	task automatic complete_run();
		$display("compared %0d, failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : complete_run

	// watchdog well beyond the hundred or so cycles the run needs
	initial begin
		repeat (3000) @(posedge clk_in);
		failures++;
		complete_run();
	end

	initial begin
		failures       = 0;
		n_compared     = 0;
		sys_rst_in     = 1'h1;
		sfr_in         = '0;
		op_valid_in    = 1'h0;
		op_in          = '0;
		repeat (20) @(posedge clk_in);
		sys_rst_in <= 1'h0;
		t_reset();
		t_status();
		t_arith();
		t_stack();
		t_pointer();
		complete_run();
	end
endmodule : cpu_core_status_registers_tb
